// File: port_j_direction_and_function_mux.sv
// Summary of operation
// - Sixteen-bit read/write direction register, one bit per pin
// - Direction bit 1 drives pin, 0 makes it input
// - Direction ignored for any other pin function; the code applies it to the timer function as well
// - Direction cleared at power-on reset and hardware standby
// - Direction kept through software standby and sleep
// - Function registers cleared likewise, kept in software standby and sleep
// - Upper register serves pins 15-8, lower pins 7-0
// - Mode bits at even positions, bit 14 is pin 15
// - Odd reserved bits read zero; software writes zero
// - Pins 15-10: general I/O or event-counter input
// - Pins 9-8: general I/O or capture/compare channel
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps

module port_j_direction_and_function_mux (
    input  wire logic                             clk_sys_i,
    input  wire logic                             nrst_i,
    input  wire logic                             ce_i,
    input  wire logic                             hw_standby_i,
    input  wire logic                             sw_standby_i,
    input  wire logic                             sleep_i,
    input  wire logic [pin_mux_pkg::ADDR_W-1:0]   avs_address_i,
    input  wire logic                             avs_read_i,
    input  wire logic                             avs_write_i,
    input  wire logic [pin_mux_pkg::DATA_W-1:0]   avs_writedata_i,
    input  wire logic [pin_mux_pkg::BE_W-1:0]     avs_byteenable_i,
    output logic      [pin_mux_pkg::DATA_W-1:0]   avs_readdata_o,
    output logic                                  avs_waitrequest_o,
    input  wire logic [pin_mux_pkg::PORT_PINS-1:0] pad_in_i,
    output logic      [pin_mux_pkg::PORT_PINS-1:0] pad_out_o,
    output logic      [pin_mux_pkg::PORT_PINS-1:0] pad_oe_o,
    input  wire logic [pin_mux_pkg::PORT_PINS-1:0] gpio_out_data_i,
    output logic      [pin_mux_pkg::PORT_PINS-1:0] gpio_in_data_o,
    output logic                                  event_count_input_a_o,
    output logic                                  event_count_input_b_o,
    output logic                                  event_count_input_c_o,
    output logic                                  event_count_input_d_o,
    output logic                                  event_count_input_e_o,
    output logic                                  event_count_input_f_o,
    input  wire logic                             capture_compare_pin_c_i,
    input  wire logic                             capture_compare_pin_d_i,
    output logic                                  capture_compare_pin_c_o,
    output logic                                  capture_compare_pin_d_o,
    input  wire logic [pin_mux_pkg::HALF_PINS-1:0] capture_compare_low_i,
    output logic      [pin_mux_pkg::HALF_PINS-1:0] capture_compare_low_o
);
    import pin_mux_pkg::*;

    // Mode bit of pin idx within its half register
    function automatic pin_func_t mode_of(input logic [15:0] func_reg,
                                          input int         idx);
        mode_of = func_reg[MODE_BIT_STRIDE * idx] ? FUNC_TIMER : FUNC_GPIO;
    endfunction

    // Both defined functions honour the direction bit
    function automatic logic dir_applies(input pin_func_t func);
        case (func)
            FUNC_GPIO:  dir_applies = 1'b1;
            FUNC_TIMER: dir_applies = 1'b1;
            default:    dir_applies = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] merge_lanes(input logic [15:0] old_val,
                                                input logic [31:0] wdata,
                                                input logic [3:0]  be);
        merge_lanes = old_val;
        if (be[0]) begin
            merge_lanes[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            merge_lanes[15:8] = wdata[15:8];
        end
    endfunction

    // Bus slave state
    bus_state_t           bus_state_ff;
    bus_state_t           nxt_bus_state;
    logic [DATA_W-1:0]    readdata_ff;
    logic [DATA_W-1:0]    nxt_readdata;

    // Configuration registers
    logic [15:0]          direction_ff;
    logic [15:0]          nxt_direction;
    logic [15:0]          upper_func_ff;
    logic [15:0]          nxt_upper_func;
    logic [15:0]          lower_func_ff;
    logic [15:0]          nxt_lower_func;

    // Timer-facing inputs
    logic [5:0]           event_in_ff;
    logic [5:0]           nxt_event_in;
    logic                 cc_c_ff;
    logic                 nxt_cc_c;
    logic                 cc_d_ff;
    logic                 nxt_cc_d;
    logic [HALF_PINS-1:0] cc_low_ff;
    logic [HALF_PINS-1:0] nxt_cc_low;

    logic [PORT_PINS-1:0] pin_level;
    pin_func_t            pin_func [PORT_PINS];
    logic                 req;
    logic                 commit;

    pin_level_sync pin_level_sync_inst (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .ce_i      (ce_i),
        .pad_in_i  (pad_in_i),
        .level_o   (pin_level)
    );

    assign req    = avs_read_i | avs_write_i;
    assign commit = req && ce_i && (bus_state_ff == BUS_ANSWER);

    // One wait state: readdata is set up before the releasing edge.
    // A frozen clock enable keeps waitrequest high, else a write
    // would be acknowledged without ever landing
    assign avs_waitrequest_o = req && !commit;
    assign avs_readdata_o    = readdata_ff;

    always_comb begin
        nxt_bus_state = bus_state_ff;
        nxt_readdata  = readdata_ff;
        case (bus_state_ff)
            BUS_IDLE: begin
                if (req) begin
                    nxt_bus_state = BUS_ANSWER;
                end
                if (avs_read_i) begin
                    case (avs_address_i)
                        OFS_DIRECTION:  nxt_readdata = {16'h0000,
                            direction_ff};
                        // Odd reserved bits never stored, so read zero
                        OFS_UPPER_FUNC: nxt_readdata = {16'h0000,
                            upper_func_ff & FUNC_WRITE_MASK};
                        OFS_LOWER_FUNC: nxt_readdata = {16'h0000,
                            lower_func_ff & FUNC_WRITE_MASK};
                        OFS_PIN_LEVEL:  nxt_readdata = {16'h0000, pin_level};
                        default:        nxt_readdata = 32'h0000_0000;
                    endcase
                end
            end
            BUS_ANSWER: begin
                nxt_bus_state = BUS_IDLE;
            end
            default: begin
                nxt_bus_state = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_state_ff <= BUS_IDLE;
            readdata_ff  <= 32'h0000_0000;
        end else if (ce_i) begin
            bus_state_ff <= nxt_bus_state;
            readdata_ff  <= nxt_readdata;
        end
    end

    // Software standby and sleep inputs deliberately have no effect on the
    // registers; only hardware standby or reset clears them
    always_comb begin
        nxt_direction  = direction_ff;
        nxt_upper_func = upper_func_ff;
        nxt_lower_func = lower_func_ff;
        if (hw_standby_i) begin
            nxt_direction  = DIR_RESET;
            nxt_upper_func = FUNC_RESET;
            nxt_lower_func = FUNC_RESET;
        end else if (commit && avs_write_i) begin
            case (avs_address_i)
                OFS_DIRECTION: begin
                    nxt_direction = merge_lanes(direction_ff,
                                                avs_writedata_i,
                                                avs_byteenable_i);
                end
                OFS_UPPER_FUNC: begin
                    nxt_upper_func = merge_lanes(upper_func_ff,
                                                 avs_writedata_i,
                                                 avs_byteenable_i)
                                     & FUNC_WRITE_MASK;
                end
                OFS_LOWER_FUNC: begin
                    nxt_lower_func = merge_lanes(lower_func_ff,
                                                 avs_writedata_i,
                                                 avs_byteenable_i)
                                     & FUNC_WRITE_MASK;
                end
                default: begin
                    nxt_direction = direction_ff;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            direction_ff  <= DIR_RESET;
            upper_func_ff <= FUNC_RESET;
            lower_func_ff <= FUNC_RESET;
        end else if (ce_i) begin
            direction_ff  <= nxt_direction;
            upper_func_ff <= nxt_upper_func;
            lower_func_ff <= nxt_lower_func;
        end
    end

    // Per-pin function from its half register
    genvar g;
    generate
        for (g = 0; g < PORT_PINS; g++) begin : g_func
            if (g >= HALF_PINS) begin : g_upper
                assign pin_func[g] = mode_of(upper_func_ff,
                    g - HALF_PINS);
            end else begin : g_lower
                assign pin_func[g] = mode_of(lower_func_ff, g);
            end
        end
    endgenerate

    // Pad drive comes straight from registers, so a write shows on the
    // pins straight after the accepting edge, with no extra cycle
    generate
        for (g = 0; g < PORT_PINS; g++) begin : g_pad
            always_comb begin
                pad_oe_o[g] = dir_applies(pin_func[g])
                              & direction_ff[g];
                pad_out_o[g] = gpio_out_data_i[g];
                if (pin_func[g] == FUNC_TIMER) begin
                    if (g == CC_PIN_C) begin
                        pad_out_o[g] = capture_compare_pin_c_i;
                    end else if (g == CC_PIN_D) begin
                        pad_out_o[g] = capture_compare_pin_d_i;
                    end else if (g < HALF_PINS) begin
                        pad_out_o[g] = capture_compare_low_i[g % HALF_PINS];
                    end
                end
            end
        end
    endgenerate

    // Event inputs see the pin only while it is routed to the timer;
    // otherwise they rest low so no spurious counts occur
    generate
        for (g = 0; g < 6; g++) begin : g_event
            always_comb begin
                nxt_event_in[g] = (pin_func[EVENT_PIN_FIRST + g] == FUNC_TIMER)
                    & pin_level[EVENT_PIN_FIRST + g];
            end
        end
        for (g = 0; g < HALF_PINS; g++) begin : g_cc_low
            always_comb begin
                nxt_cc_low[g] = (pin_func[g] == FUNC_TIMER) & pin_level[g];
            end
        end
    endgenerate

    always_comb begin
        nxt_cc_c = (pin_func[CC_PIN_C] == FUNC_TIMER)
                   & pin_level[CC_PIN_C];
        nxt_cc_d = (pin_func[CC_PIN_D] == FUNC_TIMER)
                   & pin_level[CC_PIN_D];
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            event_in_ff <= 6'h00;
            cc_c_ff     <= 1'b0;
            cc_d_ff     <= 1'b0;
            cc_low_ff   <= 8'h00;
        end else if (ce_i) begin
            event_in_ff <= nxt_event_in;
            cc_c_ff     <= nxt_cc_c;
            cc_d_ff     <= nxt_cc_d;
            cc_low_ff   <= nxt_cc_low;
        end
    end

    assign gpio_in_data_o          = pin_level;
    assign event_count_input_a_o   = event_in_ff[0];
    assign event_count_input_b_o   = event_in_ff[1];
    assign event_count_input_c_o   = event_in_ff[2];
    assign event_count_input_d_o   = event_in_ff[3];
    assign event_count_input_e_o   = event_in_ff[4];
    assign event_count_input_f_o   = event_in_ff[5];
    assign capture_compare_pin_c_o = cc_c_ff;
    assign capture_compare_pin_d_o = cc_d_ff;
    assign capture_compare_low_o   = cc_low_ff;

endmodule

// File: pin_mux_pkg.sv
package pin_mux_pkg;

    // Port geometry
    localparam int PORT_PINS       = 16;
    localparam int HALF_PINS       = 8;
    localparam int EVENT_PIN_FIRST = 10;
    localparam int CC_PIN_C        = 8;
    localparam int CC_PIN_D        = 9;
    localparam int SYNC_STAGES     = 3;

    // Bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int BE_W   = 4;

    // Register byte offsets
    localparam logic [3:0] OFS_DIRECTION  = 4'h0;
    localparam logic [3:0] OFS_UPPER_FUNC = 4'h4;
    localparam logic [3:0] OFS_LOWER_FUNC = 4'h8;
    localparam logic [3:0] OFS_PIN_LEVEL  = 4'hc;

    // Reset values and field layout
    localparam logic [15:0] DIR_RESET       = 16'h0000;
    localparam logic [15:0] FUNC_RESET      = 16'h0000;
    localparam logic [15:0] FUNC_WRITE_MASK = 16'h5555;
    localparam logic [15:0] PIN_LEVEL_RESET = 16'h0000;
    localparam int          MODE_BIT_STRIDE = 2;

    typedef enum logic {
        FUNC_GPIO,
        FUNC_TIMER
    } pin_func_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_t;

endpackage

// File: pin_level_sync.sv
`timescale 1ns/1ps

module pin_level_sync (
    input  wire logic                           clk_sys_i,
    input  wire logic                           nrst_i,
    input  wire logic                           ce_i,
    input  wire logic [pin_mux_pkg::PORT_PINS-1:0] pad_in_i,
    output logic      [pin_mux_pkg::PORT_PINS-1:0] level_o
);
    import pin_mux_pkg::*;

    logic [PORT_PINS-1:0] meta_ff;
    logic [PORT_PINS-1:0] sync2_ff;
    logic [PORT_PINS-1:0] sync3_ff;
    logic [PORT_PINS-1:0] level_ff;
    logic [PORT_PINS-1:0] nxt_level;

    // A level is accepted only once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < PORT_PINS; g++) begin : g_pin
            always_comb begin
                nxt_level[g] = (sync2_ff[g] == sync3_ff[g]) ? sync3_ff[g]
                                                              : level_ff[g];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_ff  <= PIN_LEVEL_RESET;
            sync2_ff <= PIN_LEVEL_RESET;
            sync3_ff <= PIN_LEVEL_RESET;
            level_ff <= PIN_LEVEL_RESET;
        end else if (ce_i) begin
            meta_ff  <= pad_in_i;
            sync2_ff <= meta_ff;
            sync3_ff <= sync2_ff;
            level_ff <= nxt_level;
        end
    end

    assign level_o = level_ff;

endmodule

// File: pin_mux_chk.sv
`timescale 1ns/1ps

module pin_mux_chk
    import pin_mux_pkg::*;
(
    input wire logic        clk_sys_i,
    input wire logic        nrst_i,
    input wire logic        ce_i,
    input wire logic        hw_standby_i,
    input wire logic        sw_standby_i,
    input wire logic        sleep_i,
    input wire logic [3:0]  avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic [15:0] pad_out_o,
    input wire logic [15:0] pad_oe_o,
    input wire logic [15:0] gpio_out_data_i,
    input wire logic        event_count_input_a_o,
    input wire logic        capture_compare_pin_c_i,
    input wire logic        capture_compare_pin_d_i,
    input wire logic [7:0]  capture_compare_low_i
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    logic        wr_ok;
    logic        rd_ok;
    logic        clr;
    logic [15:0] up_ff;
    logic [15:0] lo_ff;
    logic [15:0] nxt_up;
    logic [15:0] nxt_lo;

    assign wr_ok = ce_i && avs_write_i && !avs_waitrequest_o && !hw_standby_i;
    assign rd_ok = ce_i && avs_read_i && !avs_waitrequest_o;
    assign clr   = ce_i && hw_standby_i;

    // Shadow of the function registers, odd bits never stored
    function automatic logic [15:0] lanes(input logic [15:0] old,
                                          input logic [3:0]  be);
        lanes = {be[1] ? avs_writedata_i[15:8] : old[15:8],
                 be[0] ? avs_writedata_i[7:0] : old[7:0]} & FUNC_WRITE_MASK;
    endfunction

    always_comb begin
        nxt_up = clr ? 16'h0000 : up_ff;
        nxt_lo = clr ? 16'h0000 : lo_ff;
        if (wr_ok && avs_address_i == OFS_UPPER_FUNC) begin
            nxt_up = lanes(up_ff, avs_byteenable_i);
        end
        if (wr_ok && avs_address_i == OFS_LOWER_FUNC) begin
            nxt_lo = lanes(lo_ff, avs_byteenable_i);
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            up_ff <= 16'h0000;
            lo_ff <= 16'h0000;
        end else begin
            up_ff <= nxt_up;
            lo_ff <= nxt_lo;
        end
    end

    property p_oe_rd;
        rd_ok && avs_address_i == OFS_DIRECTION
            |-> avs_readdata_o == {16'h0000, pad_oe_o};
    endproperty
    a_oe_rd: assert property (p_oe_rd)
        else $error("direction readback differs from pin enables");

    property p_wr_dir;
        wr_ok && avs_address_i == OFS_DIRECTION
            && avs_byteenable_i[1:0] == 2'h3
            |=> pad_oe_o == $past(avs_writedata_i[15:0]);
    endproperty
    a_wr_dir: assert property (p_wr_dir)
        else $error("pin enables late after direction write");

    property p_oe_cause;
        $changed(pad_oe_o) |-> $past(clr)
            || $past(wr_ok && avs_address_i == OFS_DIRECTION);
    endproperty
    a_oe_cause: assert property (p_oe_cause)
        else $error("pin enables moved without cause");

    property p_hw_clr;
        clr |=> pad_oe_o == 16'h0000 && pad_out_o == gpio_out_data_i;
    endproperty
    a_hw_clr: assert property (p_hw_clr)
        else $error("hardware standby left pins enabled");

    property p_keep;
        (sw_standby_i || sleep_i) && !wr_ok && !clr |=> $stable(pad_oe_o);
    endproperty
    a_keep: assert property (p_keep)
        else $error("direction lost in low power state");

    property p_up_rd;
        rd_ok && avs_address_i == OFS_UPPER_FUNC
            |-> avs_readdata_o == {16'h0000, up_ff};
    endproperty
    a_up_rd: assert property (p_up_rd)
        else $error("upper function readback wrong");

    property p_lo_pin;
        lo_ff[0] |-> pad_out_o[0] == capture_compare_low_i[0];
    endproperty
    a_lo_pin: assert property (p_lo_pin)
        else $error("pin 0 not routed to timer");

    property p_cc_pins;
        pad_out_o[9:8] == {up_ff[2] ? capture_compare_pin_d_i
            : gpio_out_data_i[9], up_ff[0] ? capture_compare_pin_c_i
            : gpio_out_data_i[8]};
    endproperty
    a_cc_pins: assert property (p_cc_pins)
        else $error("pins 9 and 8 routed wrongly");

    // Long gap covers the whole input synchroniser
    property p_evt;
        !up_ff[4] [*8] |-> !event_count_input_a_o;
    endproperty
    a_evt: assert property (p_evt)
        else $error("event input active in general mode");

    c_wr_dir: cover property (wr_ok && avs_address_i == OFS_DIRECTION);
    c_lo_pin: cover property (lo_ff[0]);
    c_evt: cover property (event_count_input_a_o);
endmodule

bind port_j_direction_and_function_mux pin_mux_chk pin_mux_chk_inst (.*);

// File: pin_partner.sv
`timescale 1ns/1ps

module pin_partner (
    input  wire logic        clk_sys_i,
    input  wire logic        nrst_i,
    input  wire logic [15:0] pad_out_i,
    input  wire logic [15:0] pad_oe_i,
    input  wire logic [15:0] ext_level_i,
    output logic      [15:0] pad_level_o,
    output logic      [9:0]  timer_o
);
    // Undriven pins follow the outside world
    assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_level_i);

    // Timer outputs change every cycle so stale routing shows
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timer_o <= 10'h000;
        end else begin
            timer_o <= timer_o + 10'h16b;
        end
    end
endmodule

// File: port_j_direction_and_function_mux_tb.sv
`timescale 1ns/1ps

module port_j_direction_and_function_mux_tb;
    import pin_mux_pkg::*;

    logic        clk_sys_i = 1'h0, nrst_i = 1'h0, ce_i = 1'h1;
    logic        hw_standby_i = 1'h0, sw_standby_i = 1'h0, sleep_i = 1'h0;
    logic        avs_read_i = 1'h0, avs_write_i = 1'h0, avs_waitrequest_o;
    logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q;
    logic [15:0] pad_in_i, pad_out_o, pad_oe_o, gpio_in_data_o;
    logic [15:0] gpio_out_data_i = 16'h3c96, ext = 16'h0000;
    logic        event_count_input_a_o, event_count_input_b_o;
    logic        event_count_input_c_o, event_count_input_d_o;
    logic        event_count_input_e_o, event_count_input_f_o;
    logic        capture_compare_pin_c_i, capture_compare_pin_d_i;
    logic        capture_compare_pin_c_o, capture_compare_pin_d_o;
    logic [7:0]  capture_compare_low_i, capture_compare_low_o;
    logic [9:0]  tmr;
    logic [5:0]  evt;
    logic [15:0] up_tab [4] = '{16'h0000, 16'h5555, 16'h0001, 16'h4014};
    logic [15:0] lo_tab [4] = '{16'h0000, 16'h5555, 16'h0040, 16'h0001};
    int          errors = 0;
    int          comparisons = 0;

    assign capture_compare_pin_c_i = tmr[8];
    assign capture_compare_pin_d_i = tmr[9];
    assign capture_compare_low_i   = tmr[7:0];
    assign evt = {event_count_input_f_o, event_count_input_e_o,
                  event_count_input_d_o, event_count_input_c_o,
                  event_count_input_b_o, event_count_input_a_o};

    port_j_direction_and_function_mux
        port_j_direction_and_function_mux_inst (.*);

    pin_partner pin_partner_inst (
        .clk_sys_i   (clk_sys_i),
        .nrst_i      (nrst_i),
        .pad_out_i   (pad_out_o),
        .pad_oe_i    (pad_oe_o),
        .ext_level_i (ext),
        .pad_level_o (pad_in_i),
        .timer_o     (tmr)
    );

    always #50 clk_sys_i = ~clk_sys_i;

    task automatic stop_test;
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do @(posedge clk_sys_i); while (avs_waitrequest_o !== 1'h0);
        q = avs_readdata_o;
        avs_write_i <= 1'h0;
        avs_read_i <= 1'h0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'h1, a, {16'h0000, d}, 4'hf);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        bus(1'h0, a, 32'h0, 4'hf);
        check("readback", q, {16'h0000, e});
    endtask

    function automatic logic [15:0] exp_out(input logic [15:0] up, lo);
        exp_out = gpio_out_data_i;
        if (up[0]) exp_out[8] = tmr[8];
        if (up[2]) exp_out[9] = tmr[9];
        for (int i = 0; i < 8; i++) if (lo[2*i]) exp_out[i] = tmr[i];
    endfunction

    initial begin
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'h1;
        rd(OFS_DIRECTION, 16'h0000);
        rd(OFS_UPPER_FUNC, 16'h0000);
        rd(OFS_LOWER_FUNC, 16'h0000);
        wr(OFS_DIRECTION, 16'ha5c3);
        #1 check("oe", 32'(pad_oe_o), 32'h0000a5c3);
        rd(OFS_DIRECTION, 16'ha5c3);
        bus(1'h1, OFS_DIRECTION, 32'h0000ffff, 4'h1);
        rd(OFS_DIRECTION, 16'ha5ff);
        // Reserved bits written high on purpose to see them dropped
        wr(OFS_UPPER_FUNC, 16'hffff);
        rd(OFS_UPPER_FUNC, 16'h5555);
        wr(OFS_DIRECTION, 16'hffff);
        #1 check("oe", 32'(pad_oe_o), 32'h0000ffff);
        for (int k = 0; k < 4; k++) begin
            wr(OFS_UPPER_FUNC, up_tab[k]);
            wr(OFS_LOWER_FUNC, lo_tab[k]);
            repeat (2) begin
                #1 check("pad", 32'(pad_out_o),
                    32'(exp_out(up_tab[k], lo_tab[k])));
                @(posedge clk_sys_i);
                gpio_out_data_i <= ~gpio_out_data_i;
            end
        end
        wr(OFS_DIRECTION, 16'h0000);
        wr(OFS_UPPER_FUNC, 16'h5555);
        wr(OFS_LOWER_FUNC, 16'h5555);
        ext <= 16'hb6a9;
        repeat (6) @(posedge clk_sys_i);
        #1 check("evt", 32'(evt), 32'h0000002d);
        check("cc", 32'({capture_compare_pin_d_o, capture_compare_pin_c_o}),
              32'h00000002);
        check("low", 32'(capture_compare_low_o), 32'h000000a9);
        check("gpin", 32'(gpio_in_data_o), 32'h0000b6a9);
        wr(OFS_UPPER_FUNC, 16'h0000);
        sw_standby_i <= 1'h1;
        sleep_i <= 1'h1;
        repeat (6) @(posedge clk_sys_i);
        #1 check("evt", 32'(evt), 32'h00000000);
        wr(OFS_DIRECTION, 16'h1234);
        repeat (5) @(posedge clk_sys_i);
        rd(OFS_DIRECTION, 16'h1234);
        rd(OFS_LOWER_FUNC, 16'h5555);
        // Frozen clock enable must not let standby clear early
        ce_i <= 1'h0;
        hw_standby_i <= 1'h1;
        repeat (3) @(posedge clk_sys_i);
        #1 check("oe", 32'(pad_oe_o), 32'h00001234);
        @(posedge clk_sys_i);
        ce_i <= 1'h1;
        wr(OFS_DIRECTION, 16'hffff);
        hw_standby_i <= 1'h0;
        rd(OFS_DIRECTION, 16'h0000);
        rd(OFS_LOWER_FUNC, 16'h0000);
        wr(OFS_DIRECTION, 16'h00ff);
        nrst_i <= 1'h0;
        @(posedge clk_sys_i);
        #1 check("oe", 32'(pad_oe_o), 32'h00000000);
        @(posedge clk_sys_i);
        nrst_i <= 1'h1;
        rd(OFS_DIRECTION, 16'h0000);
        stop_test;
    end

    initial begin
        repeat (3000) @(posedge clk_sys_i);
        errors++;
        stop_test;
    end
endmodule
